//--- design/ldc_diag_chain.sv
// Purpose: Serial control and diagnostics of an 8-channel LED sink driver
// Assumes: Link pins are asynchronous and sampled at 100 MHz
// Notes:   The serial clock is oversampled; its edges drive the shift, readout and pulse-count logic
`timescale 1ns/1ns
`default_nettype none
module ldc_diag_chain
  import ldc_pkg::*;
(
  // System
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Serial link pins
  input  wire logic              serialClk,
  input  wire logic              serial_in,
  input  wire logic              load_strobe,
  input  wire logic              output_enable_n,
  output logic                   serial_out,
  // Analog comparator results, one means normal
  input  wire logic              tempOk,
  input  wire logic [NUM_CH-1:0] openOk,
  input  wire logic [NUM_CH-1:0] shortOk,
  // Driver controls
  output logic [NUM_CH-1:0]      led_sink_outputs,
  output logic                   reduced_test_current,
  output logic                   open_fault_flag,
  output logic                   shutdownActive
);

  // Report word from the captured status, fixed bit-to-channel mapping
  function automatic logic [7:0] reportWord(
    input ldc_rep_t   sel,
    input logic       tFlag,
    input logic [7:0] oRep,
    input logic [7:0] sRep
  );
    logic [7:0] w;
    w = REPORT_RST;
    unique case (sel)
      REP_TEMP:  w[TEMP_BIT] = tFlag;
      REP_OPEN:  w = oRep;
      REP_SHORT: w = sRep;
      default:   w = REPORT_RST;
    endcase
    return w;
  endfunction

  // Report chosen by the pulses counted in error mode
  function automatic ldc_rep_t pulseToRep(input logic [2:0] p);
    ldc_rep_t r;
    r = REP_TEMP;
    if (p == PULSE_OPEN) begin
      r = REP_OPEN;
    end else if (p == PULSE_SHORT) begin
      r = REP_SHORT;
    end
    return r;
  endfunction

  // Synchronisers
  ldc_edge_if #(.W(PIN_NUM)) pins ();
  ldc_edge_if #(.W(ANA_NUM)) ana ();

  ldc_sync #(.W(PIN_NUM)) u_pinSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({output_enable_n, load_strobe, serial_in, serialClk}),
    .edges   (pins)
  );

  ldc_sync #(.W(ANA_NUM)) u_anaSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({shortOk, openOk, tempOk}),
    .edges   (ana)
  );

  wire             sclkRise = pins.rise[PIN_SCLK];
  wire             sclkFall = pins.fall[PIN_SCLK];
  wire             sinLvl   = pins.lvl[PIN_SIN];
  wire             loadRise = pins.rise[PIN_LOAD];
  wire             loadFall = pins.fall[PIN_LOAD];
  wire             oeLvl    = pins.lvl[PIN_OE];
  wire             oeRise   = pins.rise[PIN_OE];
  wire             oeFall   = pins.fall[PIN_OE];
  wire             tempLvl  = ana.lvl[ANA_TEMP];
  wire [NUM_CH-1:0] openLvl  = ana.lvl[ANA_OPEN +: NUM_CH];
  wire [NUM_CH-1:0] shortLvl = ana.lvl[ANA_SHORT +: NUM_CH];

  // State
  ldc_mode_t   mode_r;
  ldc_rep_t    repSel_r;
  logic [2:0]  pulse_r;
  logic [7:0]  shift_r;
  logic [7:0]  data_r;
  logic        outBit_r;
  logic        serOut_r;
  logic        tempFlag_r;
  logic [7:0]  openRep_r;
  logic [7:0]  shortRep_r;
  logic        lowArm_r;
  logic        lowPend_r;
  logic        reduced_r;
  logic        shutdown_r;
  logic        openFault_r;

  // Decoding
  wire inError  = (mode_r == MODE_ERROR);
  wire errStart = loadRise && oeLvl;
  wire errPulse = inError && sclkRise;
  wire fourth   = errPulse && (pulse_r == PULSE_LOWI);
  wire errExit  = inError && loadFall;
  wire ldcPick  = errExit && (pulse_r == PULSE_LOWI);
  wire shiftEn  = !inError && sclkRise && !loadFall;

  wire ldc_rep_t repNow  = inError ? pulseToRep(pulse_r) : repSel_r;
  wire [7:0]     repLoad = reportWord(repNow, tempFlag_r, openRep_r, shortRep_r);

  // Global flag of the selected test, gated with the upstream flag
  wire globFlag = (pulse_r == PULSE_TEMP)  ? tempFlag_r :
                  (pulse_r == PULSE_OPEN)  ? (&openRep_r) :
                  (pulse_r == PULSE_SHORT) ? (&shortRep_r) : 1'b1;
  wire errOut   = sinLvl & globFlag;

  // Next values
  ldc_mode_t  mode_nxt;
  logic [2:0] pulse_nxt;
  logic [7:0] shift_nxt;
  logic [7:0] data_nxt;
  logic       serOut_nxt;

  assign mode_nxt  = errStart ? MODE_ERROR : (errExit ? MODE_NORMAL : mode_r);
  assign pulse_nxt = errStart ? PULSE_TEMP :
                     (errPulse && pulse_r != PULSE_SHDN) ? pulse_r + 3'h1 : pulse_r;

  // Load fall wins over a coincident clock edge
  assign shift_nxt = loadFall ? repLoad :
                     shiftEn ? {sinLvl, shift_r[7:1]} :
                     shift_r;

  assign data_nxt  = !loadRise ? data_r :
                     lowArm_r ? ALL_ONES :
                     shift_r;

  assign serOut_nxt = inError ? errOut :
                      sclkFall ? outBit_r :
                      serOut_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r  <= MODE_NORMAL;
      pulse_r <= PULSE_TEMP;
    end else begin
      mode_r  <= mode_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r  <= SHIFT_RST;
      outBit_r <= 1'b0;
      serOut_r <= 1'b0;
    end else begin
      shift_r  <= shift_nxt;
      serOut_r <= serOut_nxt;
      if (shiftEn) begin
        outBit_r <= shift_r[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_r <= DATA_RST;
    end else begin
      data_r <= data_nxt;
    end
  end

  // Selected report stays until another error-mode exit reselects
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      repSel_r <= REP_TEMP;
    end else if (errExit && pulse_r <= PULSE_SHORT) begin
      repSel_r <= pulseToRep(pulse_r);
    end
  end

  // Status acquired as output enable rises outside shutdown; unlit outputs read normal
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tempFlag_r <= 1'b1;
      openRep_r  <= REPORT_RST;
      shortRep_r <= REPORT_RST;
    end else if (oeRise && !shutdown_r) begin
      tempFlag_r <= tempLvl;
      openRep_r  <= openLvl | ~data_r;
      shortRep_r <= shortLvl | ~data_r;
    end
  end

  // Low-current diagnosis: arm, load ones, reduce while enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowArm_r  <= 1'b0;
      lowPend_r <= 1'b0;
      reduced_r <= 1'b0;
    end else begin
      if (ldcPick) begin
        lowArm_r  <= 1'b1;
        lowPend_r <= 1'b1;
      end else if (loadRise && lowArm_r) begin
        lowArm_r  <= 1'b0;
      end
      if (lowPend_r && oeFall) begin
        reduced_r <= 1'b1;
      end else if (reduced_r && oeRise) begin
        reduced_r <= 1'b0;
        lowPend_r <= 1'b0;
      end
    end
  end

  // Shutdown holds through ordinary transfers until a wakeup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shutdown_r <= 1'b0;
    end else if (fourth) begin
      shutdown_r <= ~sinLvl;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      openFault_r <= 1'b0;
    end else begin
      openFault_r <= ~&openRep_r;
    end
  end

  // Sinks stay dark in shutdown
  ldc_stagger #(.NCH(NUM_CH), .STEP(STAGGER_CYC)) u_stagger (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (!oeLvl && !shutdown_r),
    .pattern (data_r),
    .sinkOn  (led_sink_outputs)
  );

  assign serial_out           = serOut_r;
  assign reduced_test_current = reduced_r;
  assign open_fault_flag      = openFault_r;
  assign shutdownActive       = shutdown_r;

endmodule
`default_nettype wire

//--- design/ldc_pkg.sv
// Purpose: Shared constants and types of the LED driver diagnostic chain
// Assumes: 100 MHz system clock, 8 sink channels
// Notes:   Mode pulse counts select the error-detection functions
package ldc_pkg;

  localparam int NUM_CH   = 8;
  localparam int CLK_NS   = 10;

  // Turn-on stagger between neighbouring channels
  localparam int STAGGER_NS  = 20;
  localparam int STAGGER_CYC = (STAGGER_NS + CLK_NS - 1) / CLK_NS;

  // Positions of the synchronised link pins
  localparam int PIN_SCLK = 0;
  localparam int PIN_SIN  = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_OE   = 3;
  localparam int PIN_NUM  = 4;

  // Positions of the synchronised analog comparator results
  localparam int ANA_TEMP  = 0;
  localparam int ANA_OPEN  = 1;
  localparam int ANA_SHORT = ANA_OPEN + NUM_CH;
  localparam int ANA_NUM   = ANA_SHORT + NUM_CH;

  // Clock pulses counted while the error-detection phase runs
  localparam logic [2:0] PULSE_TEMP  = 3'h0;
  localparam logic [2:0] PULSE_OPEN  = 3'h1;
  localparam logic [2:0] PULSE_SHORT = 3'h2;
  localparam logic [2:0] PULSE_LOWI  = 3'h3;
  localparam logic [2:0] PULSE_SHDN  = 3'h4;

  // Temperature flag position in its report word
  localparam int TEMP_BIT = 0;

  // Reset values and the all-ones low-current load pattern
  localparam logic [7:0] SHIFT_RST  = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [7:0] REPORT_RST = 8'hFF;
  localparam logic [7:0] ALL_ONES   = 8'hFF;

  typedef enum logic [1:0] {
    REP_TEMP  = 2'b00,
    REP_OPEN  = 2'b01,
    REP_SHORT = 2'b10
  } ldc_rep_t;

  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_ERROR  = 1'b1
  } ldc_mode_t;

endpackage

//--- design/ldc_edge_if.sv
// Purpose: Carries synchronised levels and their edges between modules
// Assumes: Producer is ldc_sync
// Notes:   Edge strobes are one system clock wide
`timescale 1ns/1ns
`default_nettype none
interface ldc_edge_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

//--- design/ldc_sync.sv
// Purpose: Two-flop synchroniser with edge detection
// Assumes: Inputs are asynchronous to clk
// Notes:   Edges are taken from the second stage only
`timescale 1ns/1ns
`default_nettype none
module ldc_sync #(
  parameter int W = 1
) (
  // System
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Asynchronous levels
  input  wire logic [W-1:0] asyncIn,
  // Synchronised result
  ldc_edge_if.src           edges
);

  logic [W-1:0] meta_r;
  logic [W-1:0] stab_r;
  logic [W-1:0] prev_r;
  logic [2:0]   warm_r;
  logic [W-1:0] live;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      stab_r <= '0;
      prev_r <= '0;
      warm_r <= '0;
    end else begin
      meta_r <= asyncIn;
      stab_r <= meta_r;
      prev_r <= stab_r;
      warm_r <= {warm_r[1:0], 1'b1};
    end
  end

  // Edges masked until every stage holds a pin sample,
  // so an idle-high pin shows no false edge after reset
  assign live       = {W{warm_r[2]}};
  assign edges.lvl  = stab_r;
  assign edges.rise = stab_r & ~prev_r & live;
  assign edges.fall = ~stab_r & prev_r & live;

endmodule
`default_nettype wire

//--- design/ldc_stagger.sv
// Purpose: Staggered turn-on of the sink channels
// Assumes: enable is synchronous to clk
// Notes:   Turn-off is immediate on all channels to keep blanking crisp
`timescale 1ns/1ns
`default_nettype none
module ldc_stagger #(
  parameter int NCH  = 8,
  parameter int STEP = 2
) (
  // System
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // Control
  input  wire logic           enable,
  input  wire logic [NCH-1:0] pattern,
  // Sinks
  output logic      [NCH-1:0] sinkOn
);

  localparam int MAXC = (NCH - 1) * STEP;
  localparam int CW   = $clog2(MAXC + 1);

  logic [CW-1:0]  cnt_r;
  logic [NCH-1:0] reached;
  logic [NCH-1:0] sinkOn_r;

  // Step i releases channel i, channel 0 at once
  for (genvar i = 0; i < NCH; i++) begin : g_rel
    assign reached[i] = int'(cnt_r) >= i * STEP;
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !enable) begin
      cnt_r <= '0;
    end else if (cnt_r != CW'(MAXC)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sinkOn_r <= '0;
    end else begin
      sinkOn_r <= pattern & reached & {NCH{enable}};
    end
  end

  assign sinkOn = sinkOn_r;

endmodule
`default_nettype wire

//--- dv/ldc_diag_chain_checker.sv
// Purpose: Port-level checks of the diagnostic chain
// Assumes: Link pins pass a two-flop synchroniser first
// Notes:   Windows allow one cycle of slack on pin latency
`timescale 1ns/1ns
`default_nettype none
module ldc_diag_chain_checker
  import ldc_pkg::*;
(
  // System
  input wire logic              clk,
  input wire logic              sys_rst,
  // Link pins
  input wire logic              serialClk,
  input wire logic              serial_in,
  input wire logic              load_strobe,
  input wire logic              output_enable_n,
  input wire logic              serial_out,
  // Status and sinks
  input wire logic              tempOk,
  input wire logic [NUM_CH-1:0] openOk,
  input wire logic [NUM_CH-1:0] shortOk,
  input wire logic [NUM_CH-1:0] led_sink_outputs,
  input wire logic              reduced_test_current,
  input wire logic              open_fault_flag,
  input wire logic              shutdownActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_oeHigh;
    output_enable_n [*6];
  endsequence
  // Link clock high long enough for its rise to be seen
  sequence s_clkHeld;
    serialClk ##0 $past(serialClk, 2);
  endsequence

  property p_darkOff;
    s_oeHigh |-> led_sink_outputs == '0;
  endproperty
  property p_lowIOff;
    s_oeHigh |-> !reduced_test_current;
  endproperty
  property p_lowIOn;
    $rose(reduced_test_current) |-> $past(!output_enable_n, 3);
  endproperty
  property p_lowIEnd;
    $fell(reduced_test_current) |-> $past(output_enable_n, 2);
  endproperty
  // Last channel may not light before the full stagger
  property p_stagger;
    $rose(led_sink_outputs[NUM_CH-1]) |-> $past(!output_enable_n, 14);
  endproperty
  property p_shdnDark;
    shutdownActive [*2] |-> led_sink_outputs == '0;
  endproperty
  property p_shdnOn;
    $rose(shutdownActive) |-> s_clkHeld ##0 $past(!serial_in, 4);
  endproperty
  property p_shdnOff;
    $fell(shutdownActive) |-> s_clkHeld ##0 $past(serial_in, 4);
  endproperty
  property p_flagCap;
    $changed(open_fault_flag) |-> $past(output_enable_n, 3);
  endproperty

  a_darkOff: assert property (p_darkOff) else $error("sinks lit with enable off");
  a_lowIOff: assert property (p_lowIOff) else $error("test current with enable off");
  a_lowIOn: assert property (p_lowIOn) else $error("test current without enable");
  a_lowIEnd: assert property (p_lowIEnd) else $error("test current ended early");
  a_stagger: assert property (p_stagger) else $error("last channel lit too soon");
  a_shdnDark: assert property (p_shdnDark) else $error("sinks lit in shutdown");
  a_shdnOn: assert property (p_shdnOn) else $error("shutdown without request");
  a_shdnOff: assert property (p_shdnOff) else $error("wakeup without request");
  a_flagCap: assert property (p_flagCap) else $error("status taken off enable rise");
endmodule

bind ldc_diag_chain ldc_diag_chain_checker u_chk (
  .clk, .sys_rst, .serialClk, .serial_in, .load_strobe, .output_enable_n, .serial_out,
  .tempOk, .openOk, .shortOk, .led_sink_outputs, .reduced_test_current,
  .open_fault_flag, .shutdownActive
);
`default_nettype wire

//--- dv/ldc_ctrl_model.sv
// Purpose: Display controller driving a one-device chain
// Assumes: Tasks start and end at a falling clk edge
// Notes:   Link clock idles low; a bit takes 13 cycles, 130 ns
`timescale 1ns/1ns
`default_nettype none
module ldc_ctrl_model (
  // System
  input  wire logic clk,
  // Link pins
  input  wire logic serial_out,
  output var logic  serialClk,
  output var logic  serial_in,
  output var logic  load_strobe,
  output var logic  output_enable_n
);
  initial begin
    serialClk       = 1'b0;
    serial_in       = 1'b0;
    load_strobe     = 1'b0;
    output_enable_n = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data leads the rise by two cycles so both sync alike
  task automatic bitx(input logic b, output logic o);
    serial_in = b;
    step(2);
    serialClk = 1'b1;
    step(6);
    serialClk = 1'b0;
    step(5);
    o = serial_out;
  endtask

  // One device: eight clocks, first bit out is bit 0
  task automatic sh8(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[7-i]);
    end
  endtask

  // Strobe and enable change only with the link clock low
  task automatic pins(input logic l, input logic e, input logic s, input int n);
    load_strobe     = l;
    output_enable_n = e;
    serial_in       = s;
    step(n);
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench of the diagnostic chain
// Assumes: All pins change at falling clk edges
// Notes:   Fixed waits follow the pin latency of the design
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       clk     = 1'b0;
  logic       sys_rst = 1'b1;
  logic       tempOk  = 1'b1;
  logic [7:0] openOk  = 8'hFF;
  logic [7:0] shortOk = 8'hFF;
  wire logic  serialClk, serial_in, load_strobe, output_enable_n, serial_out;
  wire logic  reduced_test_current, open_fault_flag, shutdownActive;
  wire logic [7:0] led_sink_outputs;
  int         errTotal = 0;
  int         compares = 0;
  logic [7:0] q;
  logic       o;

  always #5 clk = ~clk;

  ldc_diag_chain u_dut (.clk, .sys_rst, .serialClk, .serial_in, .load_strobe, .output_enable_n,
    .serial_out, .tempOk, .openOk, .shortOk, .led_sink_outputs, .reduced_test_current,
    .open_fault_flag, .shutdownActive);
  ldc_ctrl_model u_ctl (.clk, .serial_out, .serialClk, .serial_in, .load_strobe, .output_enable_n);

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Error phase with n pulses, then read the report back
  task automatic rd(input int n, input logic [7:0] e);
    u_ctl.pins(1'b1, 1'b1, 1'b1, 10);
    repeat (n) u_ctl.bitx(1'b1, o);
    chk("globalFlag", 8'h00, {7'h0, serial_out});
    u_ctl.pins(1'b0, 1'b1, 1'b1, 10);
    u_ctl.sh8(8'hFF, q);
    chk("report", e, q);
  endtask

  task automatic t_shift();
    u_ctl.sh8(8'hC4, q);
    u_ctl.sh8(8'h3C, q);
    chk("shiftOut", 8'h23, q);
    u_ctl.pins(1'b1, 1'b0, 1'b1, 6);
    u_ctl.pins(1'b0, 1'b0, 1'b1, 30);
    chk("sinks", 8'h3C, led_sink_outputs);
  endtask

  task automatic t_temp();
    tempOk = 1'b0;
    u_ctl.step(5);
    u_ctl.pins(1'b0, 1'b1, 1'b1, 10);
    rd(0, 8'hFE);
    tempOk = 1'b1;
  endtask

  // Channel 0 fails but is unlit, so it must read normal
  task automatic t_open();
    openOk  = 8'hEA;
    shortOk = 8'h5F;
    u_ctl.sh8(8'h3C, q);
    u_ctl.pins(1'b1, 1'b0, 1'b1, 6);
    u_ctl.pins(1'b0, 1'b0, 1'b1, 30);
    u_ctl.pins(1'b0, 1'b1, 1'b1, 10);
    chk("openFlag", 8'h01, {7'h0, open_fault_flag});
    rd(1, 8'hEB);
    rd(2, 8'hDF);
    openOk  = 8'hFF;
    shortOk = 8'hFF;
  endtask

  task automatic t_lowi();
    u_ctl.sh8(8'h00, q);
    u_ctl.pins(1'b1, 1'b1, 1'b1, 10);
    repeat (3) u_ctl.bitx(1'b1, o);
    u_ctl.pins(1'b0, 1'b1, 1'b1, 10);
    u_ctl.pins(1'b1, 1'b1, 1'b0, 10);
    u_ctl.pins(1'b0, 1'b1, 1'b0, 10);
    u_ctl.pins(1'b0, 1'b0, 1'b0, 200);
    chk("lowCurrent", 8'h01, {7'h0, reduced_test_current});
    chk("sinks", 8'hFF, led_sink_outputs);
    u_ctl.pins(1'b0, 1'b1, 1'b0, 10);
    chk("lowCurrent", 8'h00, {7'h0, reduced_test_current});
    chk("openFlag", 8'h00, {7'h0, open_fault_flag});
  endtask

  task automatic shd(input logic b);
    u_ctl.pins(1'b1, 1'b1, 1'b1, 10);
    repeat (3) u_ctl.bitx(1'b1, o);
    u_ctl.bitx(b, o);
    chk("passThrough", {7'h0, b}, {7'h0, o});
    chk("shutdown", {7'h0, ~b}, {7'h0, shutdownActive});
    u_ctl.pins(1'b0, 1'b1, 1'b1, 10);
  endtask

  task automatic t_shdn();
    shd(1'b0);
    u_ctl.sh8(8'hFF, q);
    u_ctl.pins(1'b1, 1'b0, 1'b1, 6);
    u_ctl.pins(1'b0, 1'b0, 1'b1, 30);
    chk("sinksDark", 8'h00, led_sink_outputs);
    chk("shutdown", 8'h01, {7'h0, shutdownActive});
    u_ctl.pins(1'b0, 1'b1, 1'b1, 10);
    shd(1'b1);
  endtask

  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    u_ctl.step(4);
    t_shift();
    t_temp();
    t_open();
    t_lowi();
    t_shdn();
    end_of_test();
  end
endmodule
`default_nettype wire
